//--- logic/acd_pkg.sv
`default_nettype none
package acd_pkg;
  // task file offsets
  localparam logic [3:0] OFS_FEATURE = 4'h1;
  localparam logic [3:0] OFS_SECCNT = 4'h2;
  localparam logic [3:0] OFS_SECNUM = 4'h3;
  localparam logic [3:0] OFS_CYL_LO = 4'h4;
  localparam logic [3:0] OFS_CYL_HI = 4'h5;
  localparam logic [3:0] OFS_DRVHEAD = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;
  localparam logic [3:0] OFS_ALTSTAT = 4'hE;
  localparam logic [3:0] OFS_DRVADDR = 4'hF;
  // local interrupt and configuration registers
  localparam logic [3:0] OFS_EVT_STATUS = 4'h8;
  localparam logic [3:0] OFS_EVT_CLEAR = 4'h9;
  localparam logic [3:0] OFS_EVT_ENABLE = 4'hA;
  localparam logic [3:0] OFS_CONFIG = 4'hB;

  // drive/head fields
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DRIVE_BIT = 4;
  localparam int DH_HEAD_HI = 3;
  // status bits
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_DSC_BIT = 4;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_ERR_BIT = 0;
  // device control bits
  localparam int DC_SRST_BIT = 2;
  localparam int DC_IDIS_BIT = 1;
  // config bits
  localparam int CFG_IDE_BIT = 0;
  localparam int CFG_CARD_BIT = 1;
  // event bits
  localparam int EV_DONE = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_DIAG = 2;
  localparam int EV_W = 3;

  localparam logic [7:0] DRVHEAD_RESET = 8'hA0;
  localparam logic [7:0] ERR_RESET = 8'h01;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] DIAG_SLAVE_FAIL = 8'h80;
  localparam logic [7:0] PWR_SLEEP_CODE = 8'h00;
  localparam logic [7:0] PWR_IDLE_CODE = 8'hFF;
  localparam logic [8:0] SECTORS_ZERO = 9'h100;

  // field use mask: feature, count, number, cylinder, drive/head, lba
  localparam logic [5:0] USE_NONE = 6'h00;
  localparam logic [5:0] USE_DH = 6'h02;
  localparam logic [5:0] USE_SC_DH = 6'h12;
  localparam logic [5:0] USE_FR_DH = 6'h22;
  localparam logic [5:0] USE_SEEK = 6'h0F;
  localparam logic [5:0] USE_FMT = 6'h17;
  localparam logic [5:0] USE_ALL = 6'h1F;

  localparam logic [7:0] OP_DIAG = 8'h90;
  localparam logic [7:0] OP_PWR_A = 8'h98;
  localparam logic [7:0] OP_PWR_B = 8'hE5;

  typedef enum logic [1:0] {
    CLS_UNSUP = 2'b00,
    CLS_POWER = 2'b01,
    CLS_DIAG = 2'b10,
    CLS_EXEC = 2'b11
  } acd_class_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_POWER = 3'b010,
    ST_DIAG = 3'b011,
    ST_EXEC = 3'b100,
    ST_ABORT = 3'b101
  } acd_state_t;
endpackage
`default_nettype wire

//--- logic/acd_op_if.sv
`default_nettype none
interface acd_op_if;
  import acd_pkg::*;
  logic [7:0] opcode;
  acd_class_t op_class;
  logic [5:0] field_use;
  modport classifier (input opcode, output op_class, output field_use);
  modport user (output opcode, input op_class, input field_use);
endinterface
`default_nettype wire

//--- logic/acd_opcode_class.sv
`default_nettype none
module acd_opcode_class (
  acd_op_if.classifier op
);
  import acd_pkg::*;

  always_comb begin
    op.op_class = CLS_EXEC;
    op.field_use = USE_DH;
    unique casez (op.opcode)
      8'h98, 8'hE5: op.op_class = CLS_POWER;
      8'h90: op.op_class = CLS_DIAG;
      8'h20, 8'h21, 8'hC4, 8'h40, 8'h41: op.field_use = USE_ALL;
      8'h30, 8'h31, 8'h38, 8'h3C: op.field_use = USE_ALL;
      8'hC5, 8'hCD: op.field_use = USE_ALL;
      8'h91: op.field_use = USE_SC_DH;
      8'hC0, 8'hC8, 8'hCA, 8'h87: op.field_use = USE_ALL;
      8'h50: op.field_use = USE_FMT;
      8'hE3, 8'h97, 8'hC6: op.field_use = USE_SC_DH;
      8'hEF: op.field_use = USE_FR_DH;
      8'b0111????: op.field_use = USE_SEEK;
      8'b0001????, 8'h00, 8'h03, 8'hE7, 8'hEC: op.field_use = USE_DH;
      8'hE1, 8'h95, 8'hE4, 8'hE8: op.field_use = USE_DH;
      8'hE6, 8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94: op.field_use = USE_DH;
      8'hF5: op.field_use = USE_DH; // wear levelling
      8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6: begin
        op.op_class = CLS_UNSUP;
        op.field_use = USE_NONE;
      end
      8'h22, 8'h23, 8'h32, 8'h33: begin
        op.op_class = CLS_UNSUP;
        op.field_use = USE_NONE;
      end
      8'hB9: begin // any feature value
        op.op_class = CLS_UNSUP;
        op.field_use = USE_NONE;
      end
      default: begin
        op.op_class = CLS_UNSUP;
        op.field_use = USE_NONE;
      end
    endcase
  end
endmodule
`default_nettype wire

//--- logic/acd_top.sv
`default_nettype none
module acd_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic power_sleep,
  input wire logic [2:0] selftest_code,
  input wire logic slave_fail_n_pin,
  input wire logic data_req,
  input wire logic write_active,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_feature,
  output logic [5:0] cmd_field_use,
  output logic [8:0] cmd_sectors,
  output logic cmd_lba_mode,
  output logic [3:0] cmd_head,
  output logic [27:0] cmd_address,
  input wire logic cmd_done,
  input wire logic cmd_error,
  input wire logic [7:0] cmd_error_code,
  output logic host_intrq,
  output logic irq
);
  import acd_pkg::*;

  acd_op_if op ();

  acd_opcode_class u_class (
    .op(op.classifier)
  );

  function automatic logic [8:0] sector_total(input logic [7:0] count);
    sector_total = (count == 8'h00) ? SECTORS_ZERO : {1'b0, count};
  endfunction

  logic [7:0] feature_field;
  logic [7:0] sector_count_field;
  logic [7:0] sector_number_field;
  logic [15:0] cylinder_field;
  logic [7:0] drive_head_field;
  logic [7:0] command_reg;
  logic [7:0] error_reg;
  logic srst_bit;
  logic interrupt_disable_bit;
  logic ide_mode;
  logic card_id;
  logic [EV_W-1:0] evt_status;
  logic [EV_W-1:0] evt_enable;
  logic intr_pending;
  logic err_flag;
  logic busy_status_bit;
  acd_state_t state;
  acd_state_t next_state;
  logic slave_fail_meta;
  logic slave_fail_n_sync;

  logic card_select_bit;
  logic for_this_card;
  logic tf_write;
  logic cmd_write;
  logic status_read;
  logic finish;
  logic [EV_W-1:0] evt_set;
  logic [7:0] diag_result;
  logic [7:0] status_byte;
  logic [7:0] drvaddr_byte;
  logic [7:0] next_rdata;

  assign card_select_bit = drive_head_field[DH_DRIVE_BIT];
  assign busy_status_bit = (state != ST_IDLE) || srst_bit;
  // the host is locked out of the task file while busy
  assign tf_write = reg_wr && !busy_status_bit;
  assign cmd_write = tf_write && (reg_addr == OFS_STATUS);
  assign status_read = reg_rd && (reg_addr == OFS_STATUS);
  assign op.opcode = command_reg;

  // ide diagnostic runs on both devices; otherwise the drive bit decides
  always_comb begin
    for_this_card = (card_select_bit == card_id);
    if (command_reg == OP_DIAG && ide_mode) begin
      for_this_card = 1'b1;
    end
  end

  // in ide mode the master folds a slave failure into its own code
  always_comb begin
    diag_result = {5'h00, selftest_code};
    if (ide_mode && !card_id && !slave_fail_n_sync) begin
      diag_result = DIAG_SLAVE_FAIL | {5'h00, selftest_code};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slave_fail_meta <= 1'b1;
      slave_fail_n_sync <= 1'b1;
    end else begin
      slave_fail_meta <= slave_fail_n_pin;
      slave_fail_n_sync <= slave_fail_meta;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (cmd_write) begin
          next_state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (!for_this_card) begin
          next_state = ST_IDLE;
        end else begin
          unique case (op.op_class)
            CLS_POWER: next_state = ST_POWER;
            CLS_DIAG: next_state = ST_DIAG;
            CLS_EXEC: next_state = ST_EXEC;
            CLS_UNSUP: next_state = ST_ABORT;
          endcase
        end
      end
      ST_POWER: next_state = ST_IDLE;
      ST_DIAG: next_state = ST_IDLE;
      ST_ABORT: next_state = ST_IDLE;
      ST_EXEC: begin
        if (cmd_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (srst_bit) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // a command that completes raises the host interrupt, except the ide
  // slave during a diagnostic, whose status the master reports
  always_comb begin
    finish = 1'b0;
    unique case (state)
      ST_POWER, ST_ABORT: finish = 1'b1;
      ST_DIAG: finish = !(ide_mode && card_id);
      ST_EXEC: finish = cmd_done;
      default: finish = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_opcode <= 8'h00;
      cmd_feature <= 8'h00;
      cmd_field_use <= USE_NONE;
      cmd_sectors <= SECTORS_ZERO;
      cmd_lba_mode <= 1'b0;
      cmd_head <= 4'h0;
      cmd_address <= 28'h0000000;
    end else begin
      cmd_valid <= (state == ST_DECODE) && for_this_card &&
                   (op.op_class == CLS_EXEC) && !srst_bit;
      if (state == ST_DECODE) begin
        cmd_opcode <= command_reg;
        cmd_feature <= feature_field;
        cmd_field_use <= op.field_use;
        cmd_sectors <= sector_total(sector_count_field);
        cmd_lba_mode <= drive_head_field[DH_LBA_BIT];
        cmd_head <= drive_head_field[DH_HEAD_HI:0];
        cmd_address <= {drive_head_field[DH_HEAD_HI:0], cylinder_field,
                        sector_number_field};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      feature_field <= 8'h00;
      sector_number_field <= 8'h00;
      cylinder_field <= 16'h0000;
      drive_head_field <= DRVHEAD_RESET;
      command_reg <= 8'h00;
    end else if (tf_write) begin
      unique case (reg_addr)
        OFS_FEATURE: feature_field <= reg_wdata;
        OFS_SECNUM: sector_number_field <= reg_wdata;
        OFS_CYL_LO: cylinder_field[7:0] <= reg_wdata;
        OFS_CYL_HI: cylinder_field[15:8] <= reg_wdata;
        OFS_DRVHEAD: drive_head_field <= reg_wdata;
        OFS_STATUS: command_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sector_count_field <= 8'h01;
    end else if (state == ST_POWER) begin
      if (power_sleep) begin
        sector_count_field <= PWR_SLEEP_CODE;
      end else begin
        sector_count_field <= PWR_IDLE_CODE;
      end
    end else if (tf_write && reg_addr == OFS_SECCNT) begin
      sector_count_field <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      error_reg <= ERR_RESET;
      err_flag <= 1'b0;
    end else if (srst_bit) begin
      error_reg <= ERR_RESET;
      err_flag <= 1'b0;
    end else if (state == ST_DECODE) begin
      err_flag <= 1'b0;
    end else if (state == ST_ABORT) begin
      error_reg <= ERR_ABORT;
      err_flag <= 1'b1;
    end else if (state == ST_DIAG) begin
      error_reg <= diag_result;
    end else if (state == ST_EXEC && cmd_done) begin
      error_reg <= cmd_error ? cmd_error_code : 8'h00;
      err_flag <= cmd_error;
    end
  end

  // device control stays writable while busy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      srst_bit <= 1'b0;
      interrupt_disable_bit <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_ALTSTAT) begin
      srst_bit <= reg_wdata[DC_SRST_BIT];
      interrupt_disable_bit <= reg_wdata[DC_IDIS_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ide_mode <= 1'b0;
      card_id <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_CONFIG) begin
      ide_mode <= reg_wdata[CFG_IDE_BIT];
      card_id <= reg_wdata[CFG_CARD_BIT];
    end
  end

  // a completion in the same cycle as a status read stays pending
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      intr_pending <= 1'b0;
    end else if (srst_bit) begin
      intr_pending <= 1'b0;
    end else if (finish) begin
      intr_pending <= 1'b1;
    end else if (status_read) begin
      intr_pending <= 1'b0;
    end
  end

  assign host_intrq = intr_pending && !interrupt_disable_bit;

  always_comb begin
    evt_set = '0;
    evt_set[EV_DONE] = finish;
    evt_set[EV_ABORT] = (state == ST_ABORT);
    evt_set[EV_DIAG] = (state == ST_DIAG);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evt_status <= '0;
    end else if (reg_wr && reg_addr == OFS_EVT_CLEAR) begin
      evt_status <= (evt_status & ~reg_wdata[EV_W-1:0]) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evt_enable <= '0;
    end else if (reg_wr && reg_addr == OFS_EVT_ENABLE) begin
      evt_enable <= reg_wdata[EV_W-1:0];
    end
  end

  assign irq = |(evt_status & evt_enable);

  // while busy only the busy bit is meaningful
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_BUSY_BIT] = busy_status_bit;
    if (!busy_status_bit) begin
      status_byte[ST_RDY_BIT] = 1'b1;
      status_byte[ST_DSC_BIT] = 1'b1;
      status_byte[ST_DRQ_BIT] = data_req;
      status_byte[ST_ERR_BIT] = err_flag;
    end
  end

  always_comb begin
    drvaddr_byte = 8'h00;
    drvaddr_byte[6] = !write_active;
    drvaddr_byte[5:2] = ~drive_head_field[DH_HEAD_HI:0];
    drvaddr_byte[1] = !(card_select_bit && card_id);
    drvaddr_byte[0] = !(!card_select_bit && !card_id);
  end

  always_comb begin
    unique case (reg_addr)
      OFS_FEATURE: next_rdata = error_reg;
      OFS_SECCNT: next_rdata = sector_count_field;
      OFS_SECNUM: next_rdata = sector_number_field;
      OFS_CYL_LO: next_rdata = cylinder_field[7:0];
      OFS_CYL_HI: next_rdata = cylinder_field[15:8];
      OFS_DRVHEAD: next_rdata = drive_head_field;
      OFS_STATUS, OFS_ALTSTAT: next_rdata = status_byte;
      OFS_DRVADDR: next_rdata = drvaddr_byte;
      OFS_EVT_STATUS: next_rdata = {5'h00, evt_status};
      OFS_EVT_ENABLE: next_rdata = {5'h00, evt_enable};
      OFS_CONFIG: next_rdata = {6'h00, card_id, ide_mode};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- tb/acd_top_asserts.sv
`default_nettype none
module acd_top_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [5:0] cmd_field_use,
  input wire logic [8:0] cmd_sectors,
  input wire logic [3:0] cmd_head,
  input wire logic [27:0] cmd_address,
  input wire logic host_intrq
);
  timeunit 1ns;
  timeprecision 1ps;
  import acd_pkg::*;
  logic int_off;
  logic st_rd;
  logic alt_rd;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  assign st_rd = reg_rd && reg_addr == OFS_STATUS;
  assign alt_rd = reg_rd && reg_addr == OFS_ALTSTAT;
  // shadow of the host interrupt disable bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_off <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_ALTSTAT) begin
      int_off <= reg_wdata[DC_IDIS_BIT];
    end
  end
  a_valid_after_write: assert property (
    cmd_valid |-> $past(reg_wr && reg_addr == OFS_STATUS, 2))
    else $error("command out with no command write");
  a_sector_range: assert property (
    cmd_valid |-> cmd_sectors inside {[9'h001:9'h100]})
    else $error("sector count out of range");
  a_head_in_addr: assert property (
    cmd_valid |-> cmd_address[27:24] == cmd_head)
    else $error("head missing from address");
  a_rw_fields: assert property (
    cmd_valid && cmd_opcode inside {8'h20, 8'h21, 8'hC4, 8'h40, 8'h41,
      8'h30, 8'h31, 8'h38, 8'h3C, 8'hC5, 8'hCD}
      |-> cmd_field_use == USE_ALL)
    else $error("wrong field use for transfer");
  a_init_fields: assert property (
    cmd_valid && cmd_opcode == 8'h91 |-> cmd_field_use == USE_SC_DH)
    else $error("wrong field use for parameter init");
  a_wear_level: assert property (
    cmd_valid && cmd_opcode == 8'hF5 |-> cmd_field_use == USE_DH)
    else $error("wear level decoded wrongly");
  a_unsup_quiet: assert property (
    reg_wr && reg_addr == OFS_STATUS && reg_wdata inside {8'hF1, 8'hF2,
      8'hF3, 8'hF4, 8'hF6, 8'h22, 8'h23, 8'h32, 8'h33, 8'hB9}
      |-> ##2 !cmd_valid)
    else $error("unsupported opcode handed out");
  a_intrq_off: assert property (
    int_off |-> !host_intrq)
    else $error("interrupt while disabled");
  a_status_clears: assert property (
    st_rd && host_intrq |-> ##[1:2] !host_intrq)
    else $error("status read left interrupt pending");
  a_alt_keeps: assert property (
    alt_rd && host_intrq && !$past(st_rd) |=> host_intrq)
    else $error("alternate status read cleared interrupt");
endmodule
`default_nettype wire

//--- tb/acd_exec_model.sv
`default_nettype none
module acd_exec_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic slow,
  input wire logic fail,
  input wire logic [7:0] fail_code,
  output logic cmd_done,
  output logic cmd_error,
  output logic [7:0] cmd_error_code
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;
  // error lines mean nothing outside done, so they keep changing there
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_n <= 0;
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      cmd_error_code <= 8'h00;
    end else begin
      cmd_done <= 1'b0;
      cmd_error <= ~cmd_error;
      cmd_error_code <= ~cmd_error_code;
      if (cmd_valid) begin
        wait_n <= slow ? 6 : 1;
      end else if (wait_n == 1) begin
        wait_n <= 0;
        cmd_done <= 1'b1;
        cmd_error <= fail;
        cmd_error_code <= fail_code;
      end else if (wait_n > 1) begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/ata_command_decoder_test.sv
`default_nettype none
module ata_command_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import acd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic power_sleep = 1'b0;
  logic [2:0] selftest_code = 3'h1;
  logic slave_fail_n_pin = 1'b1;
  logic data_req = 1'b0;
  logic write_active = 1'b0;
  logic slow = 1'b0;
  logic fail = 1'b0;
  logic [7:0] fail_code = 8'h00;
  logic cmd_valid, cmd_lba_mode, cmd_done, cmd_error, host_intrq, irq;
  logic cap_lba;
  logic [7:0] reg_rdata, cmd_opcode, cmd_feature, cmd_error_code;
  logic [7:0] cap_op, cap_feat;
  logic [5:0] cmd_field_use, cap_use;
  logic [8:0] cmd_sectors, cap_sec;
  logic [3:0] cmd_head, cap_head;
  logic [27:0] cmd_address, cap_addr;
  int n_errors = 0;
  int compares = 0;
  int n_valid = 0;
  int cycles = 0;
  int un_q[$] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6, 8'h22, 8'h23, 8'h32,
    8'h33, 8'hB9};
  int rw_q[$] = '{8'h20, 8'h21, 8'hC4, 8'h40, 8'h41, 8'h30, 8'h31, 8'h38,
    8'h3C, 8'hC5, 8'hCD, 8'h91};
  always #2 clk_sys = ~clk_sys;
  acd_top DUT (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .power_sleep, .selftest_code, .slave_fail_n_pin, .data_req,
    .write_active, .cmd_valid, .cmd_opcode, .cmd_feature, .cmd_field_use,
    .cmd_sectors, .cmd_lba_mode, .cmd_head, .cmd_address, .cmd_done,
    .cmd_error, .cmd_error_code, .host_intrq, .irq);
  acd_exec_model far_end (.clk_sys, .rst, .cmd_valid, .slow, .fail,
    .fail_code, .cmd_done, .cmd_error, .cmd_error_code);
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cmd_valid === 1'b1) begin
      n_valid <= n_valid + 1;
      cap_use <= cmd_field_use;
      cap_sec <= cmd_sectors;
      cap_addr <= cmd_address;
      cap_lba <= cmd_lba_mode;
      cap_op <= cmd_opcode;
      cap_feat <= cmd_feature;
      cap_head <= cmd_head;
    end
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [27:0] exp,
      input logic [27:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // issue an opcode, poll without touching the pending interrupt
  task automatic run_cmd(input logic [7:0] op, output int got_valid);
    logic [7:0] s;
    int n0;
    n0 = n_valid;
    wr(OFS_STATUS, op);
    s = 8'h80;
    for (int k = 0; k < 40 && s[ST_BUSY_BIT] !== 1'b0; k++) rd(OFS_ALTSTAT, s);
    chk("busy end", 0, s[ST_BUSY_BIT]);
    got_valid = n_valid - n0;
  endtask
  initial begin
    logic [7:0] d;
    int v, cd, err_m, sc, hd, ad, hit;
    void'($urandom(32'hBB6D));
    data_req <= 1'($urandom);
    write_active <= 1'($urandom);
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_SECCNT, d);
    chk("count reset", 8'h01, d);
    rd(4'hC, d);
    chk("unmapped read", 0, d);
    rd(OFS_DRVADDR, d);
    chk("drive address", {1'b0, !write_active, 6'h3E}, d);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      power_sleep <= i[0];
      run_cmd(i[1] ? OP_PWR_B : OP_PWR_A, v);
      rd(OFS_SECCNT, d);
      chk("power count", i[0] ? 8'h00 : 8'hFF, d);
      chk("power intrq", 1, host_intrq);
      rd(OFS_ALTSTAT, d);
      chk("intrq after alt", 1, host_intrq);
      rd(OFS_STATUS, d);
      rd(OFS_ALTSTAT, d);
      chk("intrq after status", 0, host_intrq);
    end
    wr(OFS_ALTSTAT, 8'h02);
    run_cmd(OP_PWR_A, v);
    chk("intrq disabled", 0, host_intrq);
    wr(OFS_ALTSTAT, 8'h00);
    rd(OFS_ALTSTAT, d);
    chk("intrq enabled", 1, host_intrq);
    rd(OFS_STATUS, d);
    $display("test power done");
    // bit0 ide mode, bit1 drive bit, bit2 slave pin, bit3 card id
    for (int i = 0; i < 16; i++) begin
      cd = $urandom_range(5, 1);
      selftest_code <= 3'(cd);
      slave_fail_n_pin <= i[2];
      wr(OFS_CONFIG, {6'h00, i[3], i[0]});
      wr(OFS_DRVHEAD, {3'b101, i[1], 4'h0});
      run_cmd(OP_DIAG, v);
      hit = i[0] || (i[1] == i[3]);
      if (hit) err_m = (i[0] && !i[3] && !i[2]) ? (cd | 8'h80) : cd;
      hit = hit && !(i[0] && i[3]);
      rd(OFS_FEATURE, d);
      chk("diag code", err_m, d);
      chk("diag intrq", hit, host_intrq);
      rd(OFS_STATUS, d);
    end
    $display("test diagnostic done");
    wr(OFS_CONFIG, 8'h00);
    foreach (rw_q[j]) begin
      sc = (j == 0) ? 0 : (j == 1) ? 255 : $urandom_range(254, 1);
      hd = (j == 2) ? 15 : $urandom_range(15, 0);
      ad = $urandom & 32'h00FFFFFF;
      wr(OFS_SECCNT, 8'(sc));
      wr(OFS_SECNUM, ad[7:0]);
      wr(OFS_CYL_LO, ad[15:8]);
      wr(OFS_CYL_HI, ad[23:16]);
      wr(OFS_DRVHEAD, {4'hE, 4'(hd)});
      slow <= j[0];
      run_cmd(8'(rw_q[j]), v);
      chk("handed out", 1, v);
      chk("sectors", sc == 0 ? 256 : sc, cap_sec);
      chk("address", {4'(hd), ad[23:0]}, cap_addr);
      chk("fields", rw_q[j] == 8'h91 ? USE_SC_DH : USE_ALL, cap_use);
      chk("head", hd, cap_head);
      chk("lba", 1, cap_lba);
      chk("opcode", rw_q[j], cap_op);
      rd(OFS_STATUS, d);
      chk("drq bit", data_req, d[ST_DRQ_BIT]);
    end
    $display("test transfer done");
    wr(OFS_EVT_ENABLE, 8'h03);
    foreach (un_q[j]) begin
      wr(OFS_FEATURE, 8'($urandom));
      run_cmd(8'(un_q[j]), v);
      chk("unsupported", 0, v);
      rd(OFS_FEATURE, d);
      chk("abort code", 8'h04, d);
      chk("abort intrq", 1, host_intrq);
      chk("event irq", 1, irq);
      rd(OFS_STATUS, d);
      chk("error bit", 1, d[ST_ERR_BIT]);
      wr(OFS_EVT_CLEAR, 8'h07);
      rd(OFS_EVT_STATUS, d);
      chk("events cleared", 0, {d[1:0], irq});
    end
    wr(OFS_EVT_ENABLE, 8'h00);
    fail <= 1'b1;
    fail_code <= 8'h5A;
    ad = $urandom;
    wr(OFS_FEATURE, ad[7:0]);
    run_cmd(8'hF5, v);
    chk("wear level", 1, v);
    chk("wear fields", USE_DH, cap_use);
    chk("feature", ad[7:0], cap_feat);
    chk("masked irq", 0, irq);
    rd(OFS_FEATURE, d);
    chk("exec error", 8'h5A, d);
    $display("test unsupported done");
    // soft reset holds busy, restores error, drops the pending interrupt
    wr(OFS_ALTSTAT, 8'h04);
    rd(OFS_ALTSTAT, d);
    chk("soft reset status", 8'h80, d);
    rd(OFS_FEATURE, d);
    chk("soft reset error", 8'h01, d);
    chk("soft reset intrq", 0, host_intrq);
    wr(OFS_ALTSTAT, 8'h00);
    rd(OFS_ALTSTAT, d);
    chk("after soft reset", {4'h5, data_req, 3'h0}, d);
    $display("test soft reset done");
    test_done();
  end
endmodule
bind acd_top acd_top_asserts chk_i (.clk_sys, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .cmd_valid, .cmd_opcode, .cmd_field_use, .cmd_sectors,
  .cmd_head, .cmd_address, .host_intrq);
`default_nettype wire
